// *** sim/board_side.sv ***
// board side: reset sources wired to the device pins
`timescale 1ns/1ps
`default_nettype none
module board_side (
  input wire logic hw_low, // pull hardware pin low
  input wire logic pin_low, // pull reset pin low
  output logic hardware_reset_pin_n, // to device
  output logic pin_reset_input_n // to device
);
  assign hardware_reset_pin_n = !hw_low;
  // board pull-up on the reset pin, so a released pin reads high
  assign pin_reset_input_n = !pin_low;
endmodule
`default_nettype wire

// *** sim/reset_manager_sequencer_tb_top.sv ***
// testbench for the reset sequencer
`include "rst_seq_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module reset_manager_sequencer_tb_top;
  import rst_seq_pkg::*;
  logic clk, rstn, hardware_reset_pin_n, pin_reset_input_n, battery_fault_in_n;
  logic supply_fault_in_n, freq_change_busy, core_pll_locked, supplies_stable;
  logic sleep_entry, sleep_exit_req, test_reset_n, hw_low, pin_low, lo, wk;
  logic [31:0] timer_match_three, os_timer_count, awaddr, wdata, araddr, rdata;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic [3:0] wstrb;
  mode_t power_mode;
  logic reset_indicator_out_n, core_reset_n, clkcfg_reset_n, timer_reset_n, clocks_stopped;
  logic pll_enable, pins_reset, fault_sleep_req, pin_pullup_en, pin_reset_owns_pin;
  logic wake_event, boot_start;
  int fails, checked, n;
  reset_manager_sequencer #(.OSC_DIV(2), .CORE_PLL_DIV(1), .OSC_SETTLE_TICKS(8), .BIAS_CYC(10),
    .WAKE_CYC(20), .LP_HOLD_CYC(30)) u_dut (
    .clk, .rstn, .hardware_reset_pin_n, .pin_reset_input_n, .battery_fault_in_n,
    .supply_fault_in_n, .timer_match_three, .os_timer_count, .power_mode, .freq_change_busy,
    .core_pll_locked, .supplies_stable, .sleep_entry, .sleep_exit_req, .test_reset_n,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .reset_indicator_out_n,
    .core_reset_n, .clkcfg_reset_n, .timer_reset_n, .clocks_stopped, .pll_enable,
    .pins_reset, .fault_sleep_req, .pin_pullup_en, .pin_reset_owns_pin, .wake_event,
    .boot_start);
  board_side u_brd (.hw_low, .pin_low, .hardware_reset_pin_n, .pin_reset_input_n);
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task results;
    if (fails == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  // each channel drops at the rising edge that samples its ready high
  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
  endtask
  task rdc(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  // cycles until boot, noting any indicator assertion on the way
  task wboot;
    n = 0;
    lo = 1'b0;
    while (boot_start !== 1'b1 && n < 8000)
    begin
      @(negedge clk);
      n++;
      lo = lo | !reset_indicator_out_n;
    end
    chk({31'h0, boot_start}, 32'h1);
    @(posedge clk);
  endtask
  task plow(input int c);
    @(posedge clk);
    pin_low <= 1'b1;
    repeat (c) @(posedge clk);
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    fails++;
    results();
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    {hw_low, pin_low, freq_change_busy, sleep_entry, sleep_exit_req} = 5'h0;
    {battery_fault_in_n, supply_fault_in_n, core_pll_locked, supplies_stable} = 4'hf;
    {test_reset_n, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, wdata, araddr} = 96'h0;
    timer_match_three = 32'h0000_1234;
    os_timer_count = 32'h0;
    wstrb = 4'hf;
    power_mode = md_normal;
    fails = 0;
    checked = 0;
    rstn = 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    hw_low <= 1'b1;
    repeat (10) @(posedge clk);
    hw_low <= 1'b0;
    wboot();
    rdc(`OFS_CAUSE, 32'h1, `RESP_OKAY);
    rdc(`OFS_SSTAT, 32'h1, `RESP_OKAY);
    chk({31'h0, pin_pullup_en}, 32'h1);
    rdc(32'h0000_0040, 32'h0, `RESP_SLVERR);
    // watchdog, with a fault raised mid-reset that must be ignored
    wr(`OFS_WDEN, 32'h1);
    rdc(`OFS_WDEN, 32'h1, `RESP_OKAY);
    os_timer_count <= 32'h0000_1234;
    repeat (20) @(posedge clk);
    battery_fault_in_n <= 1'b0;
    repeat (20) @(posedge clk);
    {battery_fault_in_n, os_timer_count} <= 33'h1_0000_0000;
    wboot();
    chk({31'h0, lo}, 32'h1);
    rdc(`OFS_CAUSE, 32'h2, `RESP_OKAY);
    rdc(`OFS_WDEN, 32'h0, `RESP_OKAY);
    // pin reset in normal mode: short pulse ignored, long one taken
    wr(`OFS_PCFG, 32'h1);
    wr(`OFS_SCRATCH, 32'h0000_005a);
    chk({31'h0, pin_reset_owns_pin}, 32'h1);
    plow(40);
    pin_low <= 1'b0;
    chk({31'h0, core_reset_n}, 32'h1);
    plow(80);
    chk({31'h0, reset_indicator_out_n}, 32'h0);
    pin_low <= 1'b0;
    wboot();
    chk({31'h0, n < 1000}, 32'h1);
    rdc(`OFS_CAUSE, 32'h4, `RESP_OKAY);
    rdc(`OFS_SCRATCH, 32'h0, `RESP_OKAY);
    rdc(`OFS_PCFG, 32'h1, `RESP_OKAY);
    plow(80);
    pin_low <= 1'b0;
    chk({31'h0, core_reset_n}, 32'h1);
    wr(`OFS_PCFG, 32'h1);
    // frequency change masks the pin; unlocked pll lengthens the restart
    freq_change_busy <= 1'b1;
    core_pll_locked <= 1'b0;
    plow(80);
    chk({31'h0, core_reset_n}, 32'h1);
    freq_change_busy <= 1'b0;
    repeat (80) @(posedge clk);
    chk({31'h0, core_reset_n}, 32'h0);
    {pin_low, core_pll_locked} <= 2'h1;
    wboot();
    chk({31'h0, n > 1000}, 32'h1);
    // output disable set, pin stuck low past release
    wr(`OFS_PCFG, 32'h3);
    plow(1);
    wboot();
    chk({31'h0, lo}, 32'h0);
    rdc(`OFS_PCFG, 32'h2, `RESP_OKAY);
    chk({31'h0, pin_reset_owns_pin}, 32'h0);
    pin_low <= 1'b0;
    // pin reset from sleep: wake first, then reset with sleep cause
    wr(`OFS_PCFG, 32'h1);
    power_mode <= md_sleep;
    plow(1);
    wk = 1'b0;
    repeat (100) @(negedge clk) wk = wk | wake_event;
    chk({31'h0, wk}, 32'h1);
    wboot();
    pin_low <= 1'b0;
    power_mode <= md_normal;
    chk({31'h0, lo}, 32'h1);
    rdc(`OFS_CAUSE, 32'hc, `RESP_OKAY);
    // sleep-exit: lane write, scratch kept, island reset
    wstrb <= 4'h1;
    wr(`OFS_SCRATCH, 32'ha5a5_a55a);
    {wstrb, sleep_exit_req} <= 5'h1f;
    @(posedge clk);
    sleep_exit_req <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, timer_reset_n}, 32'h0);
    wboot();
    chk({31'h0, lo}, 32'h1);
    rdc(`OFS_CAUSE, 32'h8, `RESP_OKAY);
    rdc(`OFS_SCRATCH, 32'h5a, `RESP_OKAY);
    results();
  end
endmodule
`default_nettype wire

// *** sim/rst_seq_chk.sv ***
// port assertions for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module rst_seq_chk (
  input wire logic clk, // clock
  input wire logic rstn, // reset
  input wire logic hardware_reset_pin_n, // hw pin
  input wire logic freq_change_busy, // freq change
  input wire logic sleep_exit_req, // sleep exit
  input wire logic [31:0] timer_match_three, // match
  input wire logic [31:0] os_timer_count, // count
  input wire logic reset_indicator_out_n, // indicator
  input wire logic core_reset_n, // core reset
  input wire logic clkcfg_reset_n, // clock cfg reset
  input wire logic clocks_stopped, // clocks gated
  input wire logic pins_reset, // pins reset
  input wire logic fault_sleep_req, // fault request
  input wire logic boot_start // boot pulse
);
  // cycles spent in reset, and whether the clock config was reset too
  logic [15:0] cnt_r;
  logic hard_r;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_r <= 16'h0;
      hard_r <= 1'b0;
    end
    else
    begin
      cnt_r <= core_reset_n ? 16'h0 : cnt_r + 16'h1;
      hard_r <= !core_reset_n && (hard_r || !clkcfg_reset_n);
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  hw_ind_a: assert property (
    (!hardware_reset_pin_n)[*4] |-> !reset_indicator_out_n && clocks_stopped)
    else $error("indicator or clocks wrong in hw reset");
  hw_enter_a: assert property (
    !hardware_reset_pin_n |-> ##[1:3] !core_reset_n && pins_reset)
    else $error("hw reset not entered");
  fault_ign_a: assert property (
    pins_reset && $past(pins_reset) |-> !fault_sleep_req)
    else $error("fault seen during reset");
  hw_rel_a: assert property (
    $rose(hardware_reset_pin_n) |-> !reset_indicator_out_n ##[1:3] !clocks_stopped)
    else $error("early release or clocks held");
  boot_ind_a: assert property (
    boot_start |-> reset_indicator_out_n ##1 !boot_start)
    else $error("boot pulse wrong");
  seq_len_a: assert property (
    boot_start |-> cnt_r >= 16'h0203)
    else $error("sequence too short");
  full_len_a: assert property (
    boot_start && hard_r |-> cnt_r >= 16'h0618)
    else $error("full sequence too short");
  freq_ign_a: assert property (
    freq_change_busy && $past(freq_change_busy) && core_reset_n && hardware_reset_pin_n
      && !sleep_exit_req && timer_match_three != os_timer_count |=> core_reset_n)
    else $error("pin reset during freq change");
endmodule
bind reset_manager_sequencer rst_seq_chk u_chk (
  .clk(clk), .rstn(rstn), .hardware_reset_pin_n(hardware_reset_pin_n),
  .freq_change_busy(freq_change_busy), .sleep_exit_req(sleep_exit_req),
  .timer_match_three(timer_match_three), .os_timer_count(os_timer_count),
  .reset_indicator_out_n(reset_indicator_out_n), .core_reset_n(core_reset_n),
  .clkcfg_reset_n(clkcfg_reset_n), .clocks_stopped(clocks_stopped),
  .pins_reset(pins_reset), .fault_sleep_req(fault_sleep_req), .boot_start(boot_start)
);
`default_nettype wire

// *** src/reset_manager_sequencer.sv ***
// reset manager: reset sources, restart sequence, cause and config registers
//
// Notes on behaviour
// - hardware reset pin low always forces reset
// - indicator held low while hardware pin low
// - registers cleared, clocks stopped during hardware reset
// - pins default, fault inputs ignored during reset, except sleep-exit reset
// - after pin release, settle clocks then release
// - watchdog match with enable triggers reset
// - watchdog enable cleared by its reset
// - watchdog always waits full clock settling
// - watchdog or pin reset in sleep sets sleep cause too
// - pin low over 240 ns resets
// - low power: wake first, 1 ms hold
// - pull-up active until read-disable hold cleared
// - pin enable overrides pin, survives pin reset
// - pin reset ignored during frequency change
// - indicator gated by output disable bits
// - unlocked core pll waits for stabilisation
// - pin reset needs software re-enable
// - stuck-low pin clears pin reset enable
// - register groups reset per reset kind
// - timer island reset unless retained at sleep exit; hardware, watchdog and pin resets always reset it
// - oscillator 64k, pll 3, bias, 512
// - sync 3, switch 3, final 512, release
`include "rst_seq_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module reset_manager_sequencer
  import rst_seq_pkg::*;
#(
  parameter int OSC_DIV = `OSC_DIV, // clk cycles per oscillator tick
  parameter int CORE_PLL_DIV = 1, // clk cycles per core pll tick
  parameter int OSC_SETTLE_TICKS = `OSC_SETTLE, // oscillator settle ticks
  parameter int BIAS_CYC = `BIAS_CYC, // pll self-bias, clk cycles
  parameter int WAKE_CYC = `WAKE_CYC, // low-power wake hold, clk cycles
  parameter int LP_HOLD_CYC = `LP_HOLD_CYC // low-power reset hold, clk cycles
)(
  input wire logic clk, // system clock
  input wire logic rstn, // power-on reset, async
  input wire logic hardware_reset_pin_n, // hardware reset pin
  input wire logic pin_reset_input_n, // general-purpose reset pin level
  input wire logic battery_fault_in_n, // battery fault
  input wire logic supply_fault_in_n, // supply fault
  input wire logic [31:0] timer_match_three, // watchdog match value
  input wire logic [31:0] os_timer_count, // os timer counter
  input wire mode_t power_mode, // current power mode
  input wire logic freq_change_busy, // frequency change running
  input wire logic core_pll_locked, // core pll locked
  input wire logic supplies_stable, // all supplies stable
  input wire logic sleep_entry, // pulse at sleep entry
  input wire logic sleep_exit_req, // pulse to start sleep-exit reset
  input wire logic test_reset_n, // test reset
  input wire logic [31:0] awaddr, // axi write address
  input wire logic awvalid, // axi
  output logic awready, // axi
  input wire logic [31:0] wdata, // axi write data
  input wire logic [3:0] wstrb, // axi byte strobes
  input wire logic wvalid, // axi
  output logic wready, // axi
  output logic [1:0] bresp, // axi
  output logic bvalid, // axi
  input wire logic bready, // axi
  input wire logic [31:0] araddr, // axi read address
  input wire logic arvalid, // axi
  output logic arready, // axi
  output logic [31:0] rdata, // axi
  output logic [1:0] rresp, // axi
  output logic rvalid, // axi
  input wire logic rready, // axi
  output logic reset_indicator_out_n, // reset indicator to board
  output logic core_reset_n, // chip-wide internal reset
  output logic clkcfg_reset_n, // clock config/gating/state reset
  output logic timer_reset_n, // timer and pmic island reset
  output logic clocks_stopped, // internal clocks gated
  output logic pll_enable, // pll enable
  output logic pins_reset, // pins forced to reset state
  output logic fault_sleep_req, // fault request to power manager
  output logic pin_pullup_en, // pull-up on reset pin
  output logic pin_reset_owns_pin, // reset function owns the pin
  output logic wake_event, // low-power wake pulse
  output logic boot_start // pulse at reset release
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
    input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [19:0] sat_inc(input logic [19:0] v);
    return (&v) ? v : v + 20'h1;
  endfunction

  // ----------------------------------------------------------------
  // rate dividers
  // ----------------------------------------------------------------
  logic [7:0] osc_div_r;
  logic [7:0] pll_div_r;
  logic osc_tick_r;
  logic pll_tick_r;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      osc_div_r <= 8'h0;
      osc_tick_r <= 1'b0;
    end
    else
    begin
      osc_tick_r <= (osc_div_r == 8'(OSC_DIV - 1));
      osc_div_r <= (osc_div_r == 8'(OSC_DIV - 1)) ? 8'h0 : osc_div_r + 8'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pll_div_r <= 8'h0;
      pll_tick_r <= 1'b0;
    end
    else
    begin
      pll_tick_r <= (pll_div_r == 8'(CORE_PLL_DIV - 1));
      pll_div_r <= (pll_div_r == 8'(CORE_PLL_DIV - 1)) ? 8'h0 : pll_div_r + 8'h1;
    end
  end

  // ----------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------
  seq_t seq_r;
  seq_t seq_nxt;
  kind_t kind_r;
  kind_t kind_nxt;
  logic [19:0] cnt_r;
  logic [19:0] pin_cnt_r;
  logic woke_r;
  logic sleep_hit_r;
  logic pin_en_r;
  logic pin_rod_r;
  logic pmic_en_r;
  logic rdh_r;
  logic wme_r;
  logic sleep_exit_output_disable_r;
  logic sleep_keep_island_r;
  logic [31:0] scratch_r;
  logic [3:0] cause_r;
  logic island_r;
  logic armed_r;
  logic ind_n_r;

  // ----------------------------------------------------------------
  // sequence decode
  // ----------------------------------------------------------------
  wire hw_low = !hardware_reset_pin_n;
  wire pin_low = !pin_reset_input_n;
  wire seq_active = (seq_r != sq_run);
  wire run_mode = (power_mode == md_normal) || (power_mode == md_idle);
  wire lp_mode = (power_mode == md_standby) || (power_mode == md_sleep) ||
    (power_mode == md_deep_sleep);
  wire in_sleep = (power_mode == md_sleep) || (power_mode == md_deep_sleep);
  wire pin_live = pin_en_r && armed_r;
  wire step = (seq_r == sq_bias) ? 1'b1 : (seq_r == sq_final) ? pll_tick_r : osc_tick_r;
  wire [19:0] tgt = (seq_r == sq_sync) ? 20'(`SYNC_TICKS) :
    (seq_r == sq_osc) ? 20'(OSC_SETTLE_TICKS) :
    (seq_r == sq_pll_en) ? 20'(`PLL_EN_TICKS) :
    (seq_r == sq_bias) ? 20'(BIAS_CYC) :
    (seq_r == sq_pll_stab) ? 20'(`PLL_STAB_TICKS) :
    (seq_r == sq_switch) ? 20'(`SWITCH_TICKS) : 20'(`FINAL_TICKS);
  wire done = step && (cnt_r + 20'h1 >= tgt);
  wire wdt_hit = wme_r && (timer_match_three == os_timer_count);
  wire pin_run_hit = run_mode && !freq_change_busy &&
    (pin_cnt_r >= 20'(`PIN_CYC));
  wire pin_lp_hit = lp_mode && woke_r && (pin_cnt_r >= 20'(LP_HOLD_CYC));
  wire pin_hit = pin_live && pin_low && (pin_run_hit || pin_lp_hit);
  wire wake_pt = lp_mode && !woke_r && (pin_cnt_r == 20'(WAKE_CYC - 1));
  wire entry = (hw_low || (seq_r == sq_run && seq_nxt != sq_run));
  wire release_w = (seq_r == sq_final) && done;
  wire clr_a = seq_active && (kind_r != k_sleep);
  wire clr_b = seq_active && (kind_r == k_hw || kind_r == k_wdt);
  wire island_clr = seq_active && (kind_r == k_sleep) && !island_r;
  wire ind_want = (kind_nxt == k_hw) || (kind_nxt == k_wdt) ||
    (kind_nxt == k_pin && !pin_rod_r) ||
    (kind_nxt == k_sleep && !sleep_exit_output_disable_r);
  wire [3:0] cause_set = {sleep_hit_r || kind_r == k_sleep, kind_r == k_pin,
    kind_r == k_wdt, kind_r == k_hw};

  always_comb
  begin
    seq_nxt = seq_r;
    kind_nxt = kind_r;
    if (hw_low)
    begin
      seq_nxt = sq_hold;
      kind_nxt = k_hw;
    end
    else
    begin
      unique case (seq_r)
        sq_run:
        begin
          if (wdt_hit)
          begin
            seq_nxt = sq_osc;
            kind_nxt = k_wdt;
          end
          else if (pin_hit)
          begin
            seq_nxt = sq_sync;
            kind_nxt = k_pin;
          end
          else if (sleep_exit_req)
          begin
            seq_nxt = sq_pll_en;
            kind_nxt = k_sleep;
          end
        end
        sq_hold: seq_nxt = sq_osc;
        sq_sync:
        begin
          if (done)
          begin
            seq_nxt = core_pll_locked ? sq_switch : sq_pll_en;
          end
        end
        sq_osc: seq_nxt = done ? sq_pll_en : sq_osc;
        sq_pll_en: seq_nxt = done ? sq_bias : sq_pll_en;
        sq_bias: seq_nxt = done ? sq_pll_stab : sq_bias;
        sq_pll_stab: seq_nxt = done ? sq_switch : sq_pll_stab;
        sq_switch: seq_nxt = done ? sq_final : sq_switch;
        sq_final: seq_nxt = done ? sq_run : sq_final;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      seq_r <= sq_run;
      kind_r <= k_hw;
      cnt_r <= 20'h0;
    end
    else
    begin
      seq_r <= seq_nxt;
      kind_r <= kind_nxt;
      cnt_r <= (seq_nxt != seq_r || seq_r == sq_hold) ? 20'h0 : (step ? sat_inc(cnt_r) : cnt_r);
    end
  end

  // ----------------------------------------------------------------
  // pin reset detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_cnt_r <= 20'h0;
      woke_r <= 1'b0;
      wake_event <= 1'b0;
    end
    else
    begin
      wake_event <= pin_live && pin_low && !seq_active && wake_pt;
      if (!pin_live || !pin_low || seq_active || !(run_mode || lp_mode))
      begin
        pin_cnt_r <= 20'h0;
        woke_r <= 1'b0;
      end
      else if (run_mode)
      begin
        woke_r <= 1'b0;
        pin_cnt_r <= freq_change_busy ? 20'h0 : sat_inc(pin_cnt_r);
      end
      else if (!woke_r)
      begin
        woke_r <= wake_pt;
        pin_cnt_r <= wake_pt ? 20'h0 : sat_inc(pin_cnt_r);
      end
      else
      begin
        pin_cnt_r <= supplies_stable ? sat_inc(pin_cnt_r) : 20'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // reset outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ind_n_r <= 1'b0;
      core_reset_n <= 1'b0;
      clkcfg_reset_n <= 1'b0;
      timer_reset_n <= 1'b0;
      clocks_stopped <= 1'b1;
      pll_enable <= 1'b1;
      pins_reset <= 1'b1;
      fault_sleep_req <= 1'b0;
      boot_start <= 1'b0;
      sleep_hit_r <= 1'b0;
    end
    else
    begin
      if (entry)
      begin
        ind_n_r <= !ind_want;
        sleep_hit_r <= (kind_nxt == k_wdt || kind_nxt == k_pin) && in_sleep;
      end
      else if (release_w)
      begin
        ind_n_r <= 1'b1;
      end
      core_reset_n <= !(entry || (seq_active && !release_w));
      clkcfg_reset_n <= !(hw_low || clr_b);
      timer_reset_n <= !(hw_low || clr_a || island_clr);
      clocks_stopped <= hw_low;
      pll_enable <= (seq_nxt != sq_osc);
      pins_reset <= hw_low || clr_a;
      fault_sleep_req <= (!battery_fault_in_n || !supply_fault_in_n) &&
        !(hw_low || clr_a);
      boot_start <= release_w;
    end
  end

  assign reset_indicator_out_n = ind_n_r;
  assign pin_pullup_en = rdh_r;
  assign pin_reset_owns_pin = pin_en_r;

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  wire wr_fire = awvalid && awready && wvalid && wready;
  wire sel_pcfg = wr_fire && (awaddr == `OFS_PCFG);
  wire sel_sstat = wr_fire && (awaddr == `OFS_SSTAT);
  wire sel_cause = wr_fire && (awaddr == `OFS_CAUSE);
  wire sel_wden = wr_fire && (awaddr == `OFS_WDEN);
  wire sel_scfg = wr_fire && (awaddr == `OFS_SCFG);
  wire sel_scr = wr_fire && (awaddr == `OFS_SCRATCH);
  wire wr_map = sel_pcfg || sel_sstat || sel_cause || sel_wden || sel_scfg || sel_scr ||
    (awaddr == `OFS_STATUS);
  wire [31:0] pcfg_v = {29'h0, pmic_en_r, pin_rod_r, pin_en_r};
  wire [31:0] scfg_v = {30'h0, sleep_keep_island_r, sleep_exit_output_disable_r};
  wire [31:0] pcfg_w = merge(pcfg_v, wdata, wstrb);
  wire [31:0] sstat_w = merge(32'h0, wdata, wstrb);
  wire [31:0] scfg_w = merge(scfg_v, wdata, wstrb);
  wire [31:0] wden_w = merge(32'h0, wdata, wstrb);
  logic [31:0] rd_v;
  logic rd_ok;

  always_comb
  begin
    rd_ok = 1'b1;
    unique case (araddr)
      `OFS_PCFG: rd_v = pcfg_v;
      `OFS_SSTAT: rd_v = {31'h0, rdh_r};
      `OFS_CAUSE: rd_v = {28'h0, cause_r};
      `OFS_WDEN: rd_v = {31'h0, wme_r};
      `OFS_SCFG: rd_v = scfg_v;
      `OFS_SCRATCH: rd_v = scratch_r;
      `OFS_STATUS: rd_v = {29'h0, armed_r, island_r, woke_r};
      default:
      begin
        rd_v = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  // write address and data are taken together, one cycle after both are valid
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end
    else
    begin
      awready <= awvalid && wvalid && !awready && !bvalid;
      wready <= awvalid && wvalid && !awready && !bvalid;
      if (wr_fire)
      begin
        bvalid <= 1'b1;
        bresp <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bready)
      begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `RESP_OKAY;
    end
    else
    begin
      arready <= arvalid && !arready && !rvalid;
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rdata <= rd_v;
        rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (rready)
      begin
        rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // software registers; hardware clears come last and win
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_en_r <= 1'b0;
      pin_rod_r <= 1'b0;
      pmic_en_r <= 1'b0;
      armed_r <= 1'b1;
    end
    else
    begin
      if (sel_pcfg)
      begin
        pin_en_r <= pcfg_w[`B_PIN_EN];
        pin_rod_r <= pcfg_w[`B_PIN_ROD];
        pmic_en_r <= pcfg_w[`B_PMIC_EN];
        armed_r <= armed_r || pcfg_w[`B_PIN_EN];
      end
      if (entry && kind_nxt == k_pin)
      begin
        armed_r <= 1'b0;
      end
      if (hw_low || clr_a)
      begin
        pmic_en_r <= 1'b0;
        if (hw_low || kind_r != k_pin)
        begin
          pin_en_r <= 1'b0;
        end
      end
      if (hw_low || clr_b)
      begin
        pin_rod_r <= 1'b0;
      end
      if (release_w && kind_r == k_pin && pin_low)
      begin
        pin_en_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdh_r <= 1'b1;
      wme_r <= 1'b0;
      sleep_exit_output_disable_r <= 1'b0;
      sleep_keep_island_r <= 1'b0;
      scratch_r <= 32'h0;
      island_r <= 1'b0;
    end
    else
    begin
      if (sel_sstat && sstat_w[`B_RDH])
      begin
        rdh_r <= 1'b0;
      end
      if (sel_wden && wden_w[`B_WME])
      begin
        wme_r <= 1'b1;
      end
      if (sel_scfg)
      begin
        sleep_exit_output_disable_r <= scfg_w[`B_SLEEP_EXIT_OUTPUT_DISABLE];
        sleep_keep_island_r <= scfg_w[`B_SLEEP_KEEP_ISLAND];
      end
      if (sel_scr)
      begin
        scratch_r <= merge(scratch_r, wdata, wstrb);
      end
      if (sleep_entry)
      begin
        island_r <= sleep_keep_island_r || pmic_en_r || !test_reset_n;
      end
      if (hw_low || clr_a)
      begin
        rdh_r <= 1'b1;
        sleep_exit_output_disable_r <= 1'b0;
        sleep_keep_island_r <= 1'b0;
        scratch_r <= 32'h0;
      end
      if (hw_low || clr_a || island_clr)
      begin
        wme_r <= 1'b0;
      end
    end
  end

  // cause is rewritten at release; that write wins over a clearing write
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cause_r <= `CAUSE_RST;
    end
    else if (release_w)
    begin
      cause_r <= cause_set;
    end
    else if (sel_cause)
    begin
      cause_r <= cause_r & ~wdata[3:0];
    end
  end

endmodule

`default_nettype wire

// *** src/rst_seq_defines.svh ***
// register map, field positions, reset values and timing for the reset sequencer
`ifndef RST_SEQ_DEFINES_SVH
`define RST_SEQ_DEFINES_SVH
`define OFS_PCFG 32'h0000_0000
`define OFS_SSTAT 32'h0000_0004
`define OFS_CAUSE 32'h0000_0008
`define OFS_WDEN 32'h0000_000c
`define OFS_SCFG 32'h0000_0010
`define OFS_SCRATCH 32'h0000_0014
`define OFS_STATUS 32'h0000_0018
`define B_PIN_EN 0
`define B_PIN_ROD 1
`define B_PMIC_EN 2
`define B_RDH 0
`define B_WME 0
`define B_SLEEP_EXIT_OUTPUT_DISABLE 0
`define B_SLEEP_KEEP_ISLAND 1
`define B_CAUSE_HW 0
`define B_CAUSE_WDT 1
`define B_CAUSE_PIN 2
`define B_CAUSE_SLP 3
`define CAUSE_RST 4'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define CLK_MHZ 250
`define OSC_MHZ 13
`define OSC_DIV ((`CLK_MHZ + `OSC_MHZ / 2) / `OSC_MHZ)
`define PIN_NS 240
`define PIN_CYC ((`PIN_NS * `CLK_MHZ + 999) / 1000)
`define WAKE_US 100
`define WAKE_CYC (`WAKE_US * `CLK_MHZ)
`define LP_HOLD_MS 1
`define LP_HOLD_CYC (`LP_HOLD_MS * 1000 * `CLK_MHZ)
`define BIAS_US 100
`define BIAS_CYC (`BIAS_US * `CLK_MHZ - 1)
`define OSC_SETTLE 65536
`define SYNC_TICKS 3
`define PLL_EN_TICKS 3
`define PLL_STAB_TICKS 512
`define SWITCH_TICKS 3
`define FINAL_TICKS 512
`endif

// *** src/rst_seq_pkg.sv ***
// types shared by the reset sequencer
package rst_seq_pkg;
  typedef enum logic [2:0] {md_normal, md_idle, md_deep_idle, md_standby, md_sleep,
    md_deep_sleep} mode_t;
  typedef enum logic [2:0] {k_hw, k_wdt, k_pin, k_sleep} kind_t;
  typedef enum logic [3:0] {sq_run, sq_hold, sq_sync, sq_osc, sq_pll_en, sq_bias,
    sq_pll_stab, sq_switch, sq_final} seq_t;
endpackage
